// file: punch_station_defines.svh
`ifndef PUNCH_STATION_DEFINES_SVH
`define PUNCH_STATION_DEFINES_SVH
// Purpose: constants of the punch station controller
// Assumes: word-aligned AXI4-Lite register map, 32-bit data
// Notes: station numbers, function bits and status bits of the host port

`define ST_PUNCH_ST0 2'h0
`define ST_PUNCH_ST2 2'h2
`define ST_PUNCH_ST3 2'h3

// function word bits
`define FN_CLEAR_INT 0
`define FN_DATA_INT 1
`define FN_DONE_INT 2
`define FN_ALARM_INT 3
`define FN_CLEAR_CTRL 4
`define FN_FEED 5
`define FN_DEFINED_MASK 12'h03f

// level 1 status bits
`define S1_READY 0
`define S1_BUSY 1
`define S1_INT 2
`define S1_DATA 3
`define S1_DONE 4
`define S1_ALARM 5
`define S1_LOST 6

`define COLUMNS_PER_CARD 7'h50

// register byte offsets
`define REG_CMD 12'h000
`define REG_ANSWER 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_LEVEL1 12'h010
`define REG_LEVEL2 12'h014
`define REG_COLUMN 12'h018

// cmd register fields
`define CMD_KIND_LSB 16
`define CMD_STATION_LSB 20

// answer register bits
`define ANS_REPLY 0
`define ANS_REJECT 1
`define ANS_DONE 2

// irq status bits
`define IRQ_DATA 0
`define IRQ_DONE 1
`define IRQ_ALARM 2
`define IRQ_COUNT 3
`endif

// file: punch_station_pkg.sv
// Purpose: types shared by the punch station controller
// Assumes: nothing beyond the defines header
// Notes: request kinds and carriers
package punch_station_pkg;
    typedef enum logic [1:0] {
        req_status1 = 2'h0,
        req_status2 = 2'h1,
        req_function = 2'h3,
        req_output = 2'h2
    } req_kind_e;

    typedef struct packed {
        req_kind_e kind;
        logic [1:0] station;
        logic [11:0] word;
    } host_req_s;

    typedef struct packed {
        logic reply;
        logic reject;
        logic [11:0] data;
    } host_ans_s;
endpackage

// file: punch_station_engine.sv
// Purpose: station decode, status and interrupt logic of the punch part
// Assumes: one request pulse at a time, answered in the next cycle
// Notes: an unanswered request is seen by the host as an internal reject
`include "punch_station_defines.svh"
module punch_station_engine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_valid,
    input wire punch_station_pkg::host_req_s req,
    input wire logic column_taken,
    output punch_station_pkg::host_ans_s ans,
    output logic ans_valid,
    output logic [6:0] level1,
    output logic [11:0] level2,
    output logic [2:0] int_pulse,
    output logic [6:0] column_count
);
    typedef struct packed {
        punch_station_pkg::host_ans_s ans;
        logic ans_valid;
        logic data_sel;
        logic done_sel;
        logic alarm_sel;
        logic int_flag;
        logic busy;
        logic done;
        logic [11:0] level2;
        logic [2:0] int_pulse;
        logic [6:0] cols;
    } state_s;

    state_s r;
    state_s next_r;

    always_comb begin
        next_r = r;
        next_r.ans = '0;
        next_r.ans_valid = 1'b0;
        next_r.int_pulse = 3'h0;
        if (column_taken && r.busy) begin
            if (r.cols == `COLUMNS_PER_CARD - 7'h01) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                // count holds a full card so software can verify it until the next feed or clear controller
                next_r.cols = `COLUMNS_PER_CARD;
                if (r.done_sel) begin
                    next_r.int_flag = 1'b1;
                    next_r.int_pulse[`IRQ_DONE] = 1'b1;
                end
            end else begin
                next_r.cols = r.cols + 7'h01;
            end
        end
        if (req_valid) begin
            unique case (req.kind)
                punch_station_pkg::req_status1, punch_station_pkg::req_status2: begin
                    if (req.station == `ST_PUNCH_ST0 || req.station == `ST_PUNCH_ST3) begin
                        next_r.ans_valid = 1'b1;
                        next_r.ans.reply = 1'b1;
                        next_r.ans.data = 12'h001;
                    end else if (req.station == `ST_PUNCH_ST2) begin
                        next_r.ans_valid = 1'b1;
                        next_r.ans.reply = 1'b1;
                        next_r.ans.data = (req.kind == punch_station_pkg::req_status2)
                            ? r.level2 : {5'h00, level1};
                    end
                end
                punch_station_pkg::req_function: begin
                    if (req.station == `ST_PUNCH_ST2 &&
                        !(req.word[`FN_FEED] && req.word[`FN_CLEAR_CTRL])) begin
                        next_r.ans_valid = 1'b1;
                        next_r.ans.reply = 1'b1;
                        // clear interrupts keeps data and ready
                        if (req.word[`FN_CLEAR_INT]) begin
                            next_r.int_flag = 1'b0;
                            next_r.data_sel = 1'b0;
                            next_r.done_sel = 1'b0;
                            next_r.alarm_sel = 1'b0;
                        end
                        if (req.word[`FN_CLEAR_CTRL]) begin
                            next_r.int_flag = 1'b0;
                            next_r.busy = 1'b0;
                            next_r.cols = 7'h00;
                        end
                        if (req.word[`FN_DONE_INT]) begin
                            next_r.done_sel = 1'b1;
                        end
                        if (req.word[`FN_ALARM_INT]) begin
                            next_r.alarm_sel = 1'b1;
                        end
                        if (req.word[`FN_DATA_INT] && !r.busy) begin
                            next_r.data_sel = 1'b1;
                            next_r.int_flag = 1'b1;
                            next_r.int_pulse[`IRQ_DATA] = 1'b1;
                        end
                        if (req.word[`FN_FEED]) begin
                            next_r.busy = 1'b1;
                            next_r.done = 1'b0;
                            next_r.cols = 7'h00;
                        end
                    end else if (req.station == `ST_PUNCH_ST3) begin
                        next_r.ans_valid = 1'b1;
                        next_r.ans.reject = 1'b1;
                    end
                end
                punch_station_pkg::req_output: begin
                    if (req.station == `ST_PUNCH_ST2 && r.busy) begin
                        next_r.ans_valid = 1'b1;
                        next_r.ans.reply = 1'b1;
                    end else if (req.station == `ST_PUNCH_ST2) begin
                        next_r.ans_valid = 1'b1;
                        next_r.ans.reject = 1'b1;
                    end
                end
            endcase
        end
        if (!aresetn) begin
            next_r = '0;
        end
    end

    always_ff @(posedge aclk) begin
        r <= next_r;
    end

    assign ans = r.ans;
    assign ans_valid = r.ans_valid;
    assign level2 = r.level2;
    assign int_pulse = r.int_pulse;
    assign column_count = r.cols;
    // data requested whenever the punch is not mid-column
    assign level1 = {1'b0, 1'b0, r.done, !r.busy || !column_taken, r.int_flag, r.busy, 1'b1};
endmodule

// file: punch_station_ctrl.sv
// Purpose: AXI4-Lite front end of the punch station controller
// Assumes: one write and one read outstanding at a time
// Notes: a write to the cmd register issues one host request
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`include "punch_station_defines.svh"
module punch_station_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic column_taken,
    output logic [2:0] irq_line,
    output logic irq
);
    typedef struct packed {
        logic aw_done;
        logic w_done;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic req_valid;
        punch_station_pkg::host_req_s req;
        logic [2:0] answer;
        logic [11:0] ans_data;
        logic [`IRQ_COUNT:0] irq_status;
        logic [`IRQ_COUNT:0] irq_mask;
        logic [2:0] irq_line;
        logic irq;
    } state_s;

    state_s r;
    state_s next_r;
    punch_station_pkg::host_ans_s ans;
    logic ans_valid;
    logic [6:0] level1;
    logic [11:0] level2;
    logic [2:0] int_pulse;
    logic [6:0] column_count;
    logic card_error;

    punch_station_engine engine (
        .aclk(aclk),
        .aresetn(aresetn),
        .req_valid(r.req_valid),
        .req(r.req),
        .column_taken(column_taken),
        .ans(ans),
        .ans_valid(ans_valid),
        .level1(level1),
        .level2(level2),
        .int_pulse(int_pulse),
        .column_count(column_count)
    );

    assign card_error = column_taken && level1[`S1_DONE] && !level1[`S1_BUSY];

    always_comb begin
        logic [31:0] rd;
        logic [`IRQ_COUNT:0] ev;
        rd = 32'h0;
        ev = {card_error, int_pulse};
        next_r = r;
        next_r.req_valid = 1'b0;
        if (s_axi_awvalid && !r.aw_done) begin
            next_r.aw_done = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_done) begin
            next_r.w_done = 1'b1;
            next_r.wdata = s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        // engine answer is latched with the done bit set
        if (ans_valid) begin
            next_r.answer = {1'b1, ans.reject, ans.reply};
            next_r.ans_data = ans.data;
        end
        if (r.aw_done && r.w_done && !r.bvalid) begin
            next_r.aw_done = 1'b0;
            next_r.w_done = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = 2'h0;
            unique case (r.awaddr)
                `REG_CMD: begin
                    next_r.req_valid = 1'b1;
                    next_r.req.word = r.wdata[11:0];
                    next_r.req.kind = punch_station_pkg::req_kind_e'(
                        r.wdata[`CMD_KIND_LSB +: 2]);
                    next_r.req.station = r.wdata[`CMD_STATION_LSB +: 2];
                    // no done bit and no reply is an internal reject
                    next_r.answer = 3'h0;
                end
                `REG_IRQ_STATUS: begin
                    next_r.irq_status = r.irq_status & ~r.wdata[`IRQ_COUNT:0];
                end
                `REG_IRQ_MASK: begin
                    if (s_axi_wstrb[0]) begin
                        next_r.irq_mask = r.wdata[`IRQ_COUNT:0];
                    end
                end
                default: begin
                    next_r.bresp = 2'h2;
                end
            endcase
        end
        // set wins over clear
        next_r.irq_status = next_r.irq_status | ev;
        if (s_axi_rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = 2'h0;
            unique case (s_axi_araddr)
                `REG_ANSWER: rd = {17'h0, r.ans_data, r.answer};
                `REG_IRQ_STATUS: rd = {28'h0, r.irq_status};
                `REG_IRQ_MASK: rd = {28'h0, r.irq_mask};
                `REG_LEVEL1: rd = {25'h0, level1};
                `REG_LEVEL2: rd = {20'h0, level2};
                `REG_COLUMN: rd = {25'h0, column_count};
                `REG_CMD: rd = {30'h0, r.req_valid, 1'b0};
                default: next_r.rresp = 2'h2;
            endcase
            next_r.rdata = rd;
        end
        next_r.irq_line = next_r.irq_status[2:0] & next_r.irq_mask[2:0];
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);
        if (!aresetn) begin
            next_r = '0;
        end
    end

    always_ff @(posedge aclk) begin
        r <= next_r;
    end

    assign s_axi_awready = !r.aw_done && !r.bvalid && aresetn;
    assign s_axi_wready = !r.w_done && !r.bvalid && aresetn;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = !r.rvalid && aresetn;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign irq_line = r.irq_line;
    assign irq = r.irq;
endmodule

// file: punch_station_ctrl_assertions.sv
// Purpose: port checks of the punch station controller
// Assumes: one clock, synchronous active low reset
// Notes: bound to every punch_station_ctrl instance
`include "punch_station_defines.svh"
module punch_station_ctrl_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic column_taken,
    input wire logic [2:0] irq_line,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic ar_take;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data withdrawn early");
    read_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered in two cycles");
    hole_read_a: assert property (ar_take && s_axi_araddr > `REG_COLUMN
        |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
    good_read_a: assert property (ar_take && s_axi_araddr <= `REG_COLUMN
        && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == 2'h0) else $error("mapped read refused");
    line_sum_a: assert property (irq_line != 3'h0 |-> irq)
        else $error("interrupt line without summary");
    reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && irq_line == 3'h0 && !irq) else $error("outputs busy after reset");
    cover property (irq_line[0]);
    cover property (irq_line[1]);
    cover property (ar_take && s_axi_araddr > `REG_COLUMN);
endmodule
bind punch_station_ctrl punch_station_ctrl_assertions punch_station_ctrl_assertions_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .column_taken(column_taken), .irq_line(irq_line), .irq(irq));

// file: punch_mech_model.sv
// Purpose: punch mechanism that takes one column per hand-over
// Assumes: go pulses once for every column handed over
// Notes: delay varies per column so prompt and slow takes both occur
module punch_mech_model (
    input wire logic aclk,
    input wire logic go,
    input wire logic [2:0] delay,
    output logic column_taken
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt = 4'h0;
    initial column_taken = 1'b0;
    always @(posedge aclk) begin
        column_taken <= (cnt == 4'h1);
        if (go)
            cnt <= {1'b0, delay} + 4'h2;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule

// file: card_punch_station_control_bench.sv
// Purpose: self-checking bench of the punch station controller
// Assumes: answer register settles within four cycles of a command
// Notes: random function words and column delays from a fixed seed
`include "punch_station_defines.svh"
module card_punch_station_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam punch_station_pkg::req_kind_e k_l1 = punch_station_pkg::req_status1;
    localparam punch_station_pkg::req_kind_e k_fn = punch_station_pkg::req_function;
    localparam punch_station_pkg::req_kind_e k_out = punch_station_pkg::req_output;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, column_taken, irq, go = 1'b0;
    logic [1:0] bresp, rresp;
    logic [2:0] irq_line, delay = 3'h0;
    int err_count = 0, cmp_count = 0, seed = 32'h71896e24;
    punch_station_ctrl punch_station_ctrl_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .column_taken(column_taken), .irq_line(irq_line), .irq(irq));
    punch_mech_model punch_mech_model_i (.aclk(aclk), .go(go), .delay(delay),
        .column_taken(column_taken));
    initial forever #2.5 aclk = ~aclk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // aw and w offered together, bready held until the response edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [2:0] dn;
        dn = 3'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && dn != 3'h7; n++) begin
            @(posedge aclk);
            dn[0] = dn[0] | (awvalid & awready);
            dn[1] = dn[1] | (wvalid & wready);
            dn[2] = bvalid;
            awvalid <= !dn[0];
            wvalid <= !dn[1];
            bready <= !dn[2];
        end
        if (dn != 3'h7) begin
            err_count++;
            close_out();
        end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic [1:0] dn;
        dn = 2'h0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !dn[1]; n++) begin
            @(posedge aclk);
            dn[0] = dn[0] | (arvalid & arready);
            dn[1] = rvalid;
            d = rdata;
            r = rresp;
            arvalid <= !dn[0];
            rready <= !dn[1];
        end
        if (!dn[1]) begin
            err_count++;
            close_out();
        end
        @(posedge aclk);
    endtask
    // reply is 01, silence (internal reject) is 00
    task automatic op(input string nm, input punch_station_pkg::req_kind_e k,
            input logic [1:0] st, input logic [11:0] w, input logic [1:0] ea,
            output logic [11:0] s);
        logic [31:0] d;
        logic [1:0] r;
        wr(`REG_CMD, {10'h000, st, 2'h0, k, 4'h0, w});
        repeat (4) @(posedge aclk);
        rd(`REG_ANSWER, d, r);
        check(nm, 32'(d[1:0]), 32'(ea));
        s = d[14:3];
    endtask
    function automatic logic [31:0] lvl1(input logic intr, input logic busy);
        lvl1 = 32'h0;
        lvl1[`S1_READY] = 1'b1;
        lvl1[`S1_DATA] = 1'b1;
        lvl1[`S1_INT] = intr;
        lvl1[`S1_BUSY] = busy;
    endfunction
    initial begin
        logic [11:0] s;
        logic [31:0] d;
        logic [1:0] r;
        logic [11:0] w;
        logic [11:0] idle_fn[3] = '{12'h010, 12'h001, 12'h004};
        logic [11:0] irq_fn[2] = '{12'h002, 12'h01f};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        op("st0 answer", k_l1, 2'h0, 12'h000, 2'h1, s);
        check("st0 status", 32'(s), 32'h1);
        op("st3 answer", k_l1, 2'h3, 12'h000, 2'h1, s);
        check("st3 ready", 32'(s[`S1_READY]), 32'h1);
        op("st0 function", k_fn, 2'h0, 12'h03f, 2'h0, s);
        op("st2 all functions", k_fn, 2'h2, 12'h03f, 2'h0, s);
        op("st0 again", k_l1, 2'h0, 12'h000, 2'h1, s);
        check("ready after reject", 32'(s), 32'h1);
        op("st2 answer", k_l1, 2'h2, 12'h000, 2'h1, s);
        check("st2 idle", 32'(s), lvl1(1'b0, 1'b0));
        op("level2 answer", punch_station_pkg::req_status2, 2'h2, 12'h000, 2'h1, s);
        check("level2 word", 32'(s), 32'h0);
        rd(12'h01c, d, r);
        check("unmapped read", 32'(r), 32'h2);
        $display("static station test done");
        wr(`REG_IRQ_MASK, 32'h7);
        foreach (idle_fn[i]) begin
            op("quiet function", k_fn, 2'h2, idle_fn[i], 2'h1, s);
            op("quiet status", k_l1, 2'h2, 12'h000, 2'h1, s);
            check("quiet level1", 32'(s), lvl1(1'b0, 1'b0));
            check("quiet lines", 32'(irq_line), 32'h0);
        end
        for (int i = 0; i < 20; i++) begin
            // only undefined bits: feed or data interrupt would change the status answer
            w = 12'($random(seed)) & ~`FN_DEFINED_MASK | 12'h040;
            op("undefined code", k_fn, 2'h2, w, 2'h1, s);
            op("undefined status", k_l1, 2'h2, 12'h000, 2'h1, s);
            check("undefined level1", 32'(s), lvl1(1'b0, 1'b0));
        end
        $display("function test done");
        foreach (irq_fn[i]) begin
            op("data int request", k_fn, 2'h2, irq_fn[i], 2'h1, s);
            op("data int status", k_l1, 2'h2, 12'h000, 2'h1, s);
            check("data int level1", 32'(s), lvl1(1'b1, 1'b0));
            check("only data line", 32'(irq_line), 32'h1);
            rd(`REG_IRQ_STATUS, d, r);
            check("sticky data bit", 32'(d[2:0]), 32'h1);
            wr(`REG_IRQ_MASK, 32'h6);
            repeat (2) @(posedge aclk);
            check("masked line", 32'({irq, irq_line}), 32'h0);
            wr(`REG_IRQ_MASK, 32'h7);
            wr(`REG_IRQ_STATUS, 32'h1);
            repeat (2) @(posedge aclk);
            check("cleared line", 32'(irq_line), 32'h0);
            op("clear ctrl", k_fn, 2'h2, 12'h010, 2'h1, s);
        end
        $display("interrupt test done");
        op("feed with done", k_fn, 2'h2, 12'h024, 2'h1, s);
        for (int c = 1; c <= 80; c++) begin
            op("column out", k_out, 2'h2, 12'($random(seed)), 2'h1, s);
            op("column status", k_l1, 2'h2, 12'h000, 2'h1, s);
            check("busy ready", 32'(s[1:0]), 32'h3);
            check("early done", 32'(irq_line[1]), 32'h0);
            go <= 1'b1;
            delay <= 3'($random(seed));
            @(posedge aclk);
            go <= 1'b0;
            for (int n = 0; n < 20 && !column_taken; n++)
                @(posedge aclk);
        end
        for (int n = 0; n < 40 && !irq_line[1]; n++)
            @(posedge aclk);
        check("done line", 32'(irq_line[1]), 32'h1);
        rd(`REG_COLUMN, d, r);
        check("column count", 32'(d[6:0]), 32'(`COLUMNS_PER_CARD));
        // one column beyond a full card must flag the count error
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (16) @(posedge aclk);
        rd(`REG_IRQ_STATUS, d, r);
        check("extra column error", 32'(d[3]), 32'h1);
        $display("punch test done");
        close_out();
    end
    initial begin
        repeat (100000) @(posedge aclk);
        err_count++;
        close_out();
    end
endmodule
